// file: core/sbcp_map.svh
`ifndef SBCP_MAP_SVH
`define SBCP_MAP_SVH
// Register pointers of the serial control port
`define SBCP_REG_STATUS    8'h0C
`define SBCP_REG_CTRL      8'h14
`define SBCP_REG_BUILTIN_SELFTEST_CNT  8'h20
`define SBCP_REG_FUNC_CNT  8'h21
// Field positions
`define SBCP_LOCK_BIT      0
`define SBCP_OSC25_BIT     0
`define SBCP_BCLR_BIT      1
`define SBCP_FCLR_BIT      2
// Reset values
`define SBCP_CTRL_RST      1'b0
`define SBCP_CNT_RST       8'h00
`define SBCP_CNT_MAX       8'hFF
`define SBCP_SCR_SEED      24'hFFFFFF
`define SBCP_ADDR_BASE     7'h0C
`define SBCP_STRAP_WAIT    2'h2
`define SBCP_STRAP_DONE    2'h3
// Strap thresholds, 15 ascending 8-bit codes of the voltage ratio
`define SBCP_STRAP_THR     120'hAE_9B_90_84_78_6D_61_55_4B_42_3A_33_2B_23_10
`define SBCP_STRAP_STEPS   15
// Timing
`define SBCP_MCLK_MHZ      10
`define SBCP_PCLK_LOSS_NS  2000
`define SBCP_PCLK_LOSS_CYC 8'((`SBCP_PCLK_LOSS_NS * `SBCP_MCLK_MHZ) / 1000)
`define SBCP_OSC33_DIV     4'h3
`define SBCP_OSC25_DIV     4'h4
`define SBCP_OSC12_DIV     4'h8
`define SBCP_DCB_HALF      5'd12
`endif

// file: core/sbcp_pkg.sv
package sbcp_pkg;
  typedef enum logic [1:0] {SBCP_NORMAL, SBCP_WAKE, SBCP_SELFTEST} sbcp_mode_t;
  typedef enum logic [1:0] {SBCP_OSC_33, SBCP_OSC_25, SBCP_OSC_12P5} sbcp_osc_t;
  typedef enum logic [2:0] {
    SBCP_I_IDLE, SBCP_I_ADDR, SBCP_I_AACK, SBCP_I_WR, SBCP_I_WACK, SBCP_I_RD, SBCP_I_RACK
  } sbcp_i2c_t;
endpackage

// file: core/sbcp_i2c_slave.sv
`timescale 1ns/1ns
`default_nettype none
module sbcp_i2c_slave
  import sbcp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [6:0] dev_addr,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rd_data,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic [7:0]      wr_data,
  output logic [7:0]      ptr
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  sbcp_i2c_t  st_r;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  logic       done_r;
  logic       rw_r;
  logic       first_r;
  logic       rise;
  logic       fall;
  logic       start_det;
  logic       stop_det;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else if (clk_en) begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end
  assign rise      = scl_s[1] & ~scl_s[2];
  assign fall      = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_det  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= SBCP_I_IDLE; sh_r <= 8'h00; cnt_r <= 3'h0; done_r <= 1'b0;
      rw_r <= 1'b0; first_r <= 1'b0; sda_oe <= 1'b0; wr_stb <= 1'b0;
      wr_data <= 8'h00; ptr <= 8'h00;
    end else if (clk_en) begin
      wr_stb <= 1'b0;
      if (stop_det) begin
        st_r <= SBCP_I_IDLE;
        sda_oe <= 1'b0;
      end else if (start_det) begin
        st_r <= SBCP_I_ADDR;
        cnt_r <= 3'h0;
        done_r <= 1'b0;
        sda_oe <= 1'b0;
      end else if (rise) begin
        case (st_r)
          SBCP_I_ADDR, SBCP_I_WR: begin
            sh_r <= {sh_r[6:0], sda_s[1]};
            cnt_r <= cnt_r + 3'h1;
            done_r <= (cnt_r == 3'h7);
          end
          SBCP_I_RACK: if (sda_s[1]) st_r <= SBCP_I_IDLE;
          default: ;
        endcase
      end else if (fall) begin
        case (st_r)
          SBCP_I_ADDR: if (done_r) begin
            done_r <= 1'b0;
            sda_oe <= (sh_r[7:1] == dev_addr);
            st_r <= (sh_r[7:1] == dev_addr) ? SBCP_I_AACK : SBCP_I_IDLE;
            rw_r <= sh_r[0];
          end
          SBCP_I_WR: if (done_r) begin
            done_r <= 1'b0;
            sda_oe <= 1'b1;
            st_r <= SBCP_I_WACK;
            if (first_r) ptr <= sh_r;
            else begin
              wr_stb <= 1'b1;
              wr_data <= sh_r;
            end
          end
          SBCP_I_AACK: begin
            cnt_r <= 3'h0;
            first_r <= ~rw_r;
            st_r <= rw_r ? SBCP_I_RD : SBCP_I_WR;
            sh_r <= rd_data;
            sda_oe <= rw_r & ~rd_data[7];
          end
          SBCP_I_WACK: begin
            if (!first_r) ptr <= ptr + 8'h01;
            first_r <= 1'b0;
            sda_oe <= 1'b0;
            cnt_r <= 3'h0;
            st_r <= SBCP_I_WR;
          end
          SBCP_I_RD: if (cnt_r == 3'h7) begin
            sda_oe <= 1'b0;
            ptr <= ptr + 8'h01;
            st_r <= SBCP_I_RACK;
          end else begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe <= ~sh_r[6];
            cnt_r <= cnt_r + 3'h1;
          end
          SBCP_I_RACK: begin
            st_r <= SBCP_I_RD;
            sh_r <= rd_data;
            sda_oe <= ~rd_data[7];
            cnt_r <= 3'h0;
          end
          default: st_r <= SBCP_I_IDLE;
        endcase
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_stop_idle;
    clk_en && stop_det |=> st_r == SBCP_I_IDLE && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not release bus");
  property p_addr_ack;
    clk_en && fall && !stop_det && !start_det && st_r == SBCP_I_ADDR && done_r |=>
      sda_oe == ($past(sh_r[7:1]) == dev_addr);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_data_ack;
    clk_en && fall && !stop_det && !start_det && st_r == SBCP_I_WR && done_r |=> sda_oe;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("write byte not acked");
  c_write: cover property (clk_en && wr_stb);
endmodule
`default_nettype wire

// file: core/sbcp_top.sv
// Operation
// - No self-test in backward compatible mode
// - Remote request starts at-speed test transmission
// - Powered down: wake first, then test
// - Self-test replaces parallel inputs with zeros
// - Zero payload still scrambled and DC-balanced
// - Normal range: pixel clock or 33/25 oscillator
// - Low range: pixel clock or 12.5 oscillator
// - Remote enable low ends self-test
// - Count CRC errors only when back channel locked
// - CRC error counters are eight bits
// - Self-test counter cleared on self-test entry
// - Functional counter counts outside self-test
// - Self-test counter holds total until cleared
// - Pattern generator transmits without parallel input
// - Pattern generator may run from oscillator
// - Strap ratio decodes to addresses 0x0C-0x1B
// - Transactions start with START, end with STOP
// - Ack matching address, release on mismatch
// - Ack every received write byte
// - Range flag selects low pixel clock band
`timescale 1ns/1ns
`default_nettype none
`include "sbcp_map.svh"
module sbcp_top
  import sbcp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        remote_selftest_enable,
  input  wire logic        backward_compat,
  input  wire logic        power_down,
  input  wire logic        pattern_gen_enable,
  input  wire logic        low_frequency_range,
  input  wire logic        selftest_clock_select,
  input  wire logic        pixel_clock,
  input  wire logic [23:0] parallel_data,
  input  wire logic        back_channel_locked,
  input  wire logic        back_channel_crc_error,
  input  wire logic [7:0]  address_strap_pin_code,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic [23:0]      tx_word,
  output logic             tx_dc_invert,
  output logic             tx_valid,
  output logic             selftest_active,
  output logic             wake_request,
  output logic             use_internal_oscillator,
  output logic [1:0]       osc_rate,
  output logic             pixel_range_low,
  output logic [7:0]       builtin_selftest_crc_count,
  output logic [7:0]       func_crc_count,
  output logic             link_detect,
  output logic [6:0]       device_address
);
  sbcp_mode_t  mode_r;
  sbcp_mode_t  mode_nxt;
  sbcp_osc_t   rate_nxt;
  logic [2:0]  pclk_s;
  logic [23:0] par_s1;
  logic [23:0] par_s2;
  logic [7:0]  strap_s1;
  logic [7:0]  strap_s2;
  logic [1:0]  strap_wait_r;
  logic [7:0]  gap_r;
  logic        pclk_rise;
  logic        pclk_present;
  logic [3:0]  div_r;
  logic        osc_tick;
  logic        word_stb;
  logic        sending;
  logic [23:0] src_word;
  logic [23:0] lfsr_r;
  logic [23:0] scr_word;
  logic [7:0]  pat_r;
  logic        in_st;
  logic        entering;
  logic        crc_err;
  logic        osc25_r;
  logic        bclr;
  logic        fclr;
  logic        wr_stb;
  logic [7:0]  wr_data;
  logic [7:0]  ptr;
  logic [7:0]  rd_data;
  logic        slave_oe;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == `SBCP_CNT_MAX) ? v : v + 8'h01;
  endfunction

  function automatic logic [3:0] osc_div(input sbcp_osc_t r);
    case (r)
      SBCP_OSC_25:   osc_div = `SBCP_OSC25_DIV;
      SBCP_OSC_12P5: osc_div = `SBCP_OSC12_DIV;
      default:       osc_div = `SBCP_OSC33_DIV;
    endcase
  endfunction

  function automatic logic [4:0] ones(input logic [23:0] v);
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < 24; i++) n = n + {4'h0, v[i]};
    ones = n;
  endfunction

  function automatic logic [3:0] strap_index(input logic [7:0] code);
    logic [119:0] thr;
    logic [3:0]   idx;
    thr = `SBCP_STRAP_THR;
    idx = 4'h0;
    for (int i = 0; i < `SBCP_STRAP_STEPS; i++)
      if (code >= thr[i*8 +: 8]) idx = 4'(i + 1);
    strap_index = idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pclk_s <= 3'h0;
      par_s1 <= 24'h000000;
      par_s2 <= 24'h000000;
      strap_s1 <= 8'h00;
      strap_s2 <= 8'h00;
    end else if (clk_en) begin
      pclk_s <= {pclk_s[1:0], pixel_clock};
      par_s1 <= parallel_data;
      par_s2 <= par_s1;
      strap_s1 <= address_strap_pin_code;
      strap_s2 <= strap_s1;
    end
  end
  assign pclk_rise = pclk_s[1] & ~pclk_s[2];

  // Strap caught once, after the sync chain has filled with the pin value
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strap_wait_r <= 2'h0;
      device_address <= `SBCP_ADDR_BASE;
    end else if (clk_en && strap_wait_r != `SBCP_STRAP_DONE) begin
      strap_wait_r <= strap_wait_r + 2'h1;
      if (strap_wait_r == `SBCP_STRAP_WAIT) device_address <= `SBCP_ADDR_BASE + {3'h0, strap_index(strap_s2)};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-test mode control
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      SBCP_NORMAL:
        if (remote_selftest_enable && !backward_compat)
          mode_nxt = power_down ? SBCP_WAKE : SBCP_SELFTEST;
      SBCP_WAKE:
        if (!remote_selftest_enable || backward_compat) mode_nxt = SBCP_NORMAL;
        else if (!power_down) mode_nxt = SBCP_SELFTEST;
      SBCP_SELFTEST:
        if (!remote_selftest_enable || backward_compat) mode_nxt = SBCP_NORMAL;
      default: mode_nxt = SBCP_NORMAL;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_r <= SBCP_NORMAL;
      selftest_active <= 1'b0;
      wake_request <= 1'b0;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      selftest_active <= (mode_nxt == SBCP_SELFTEST);
      wake_request <= (mode_nxt == SBCP_WAKE);
    end
  end
  assign in_st    = (mode_r == SBCP_SELFTEST);
  assign entering = (mode_nxt == SBCP_SELFTEST) && !in_st;

  ////////////////////////////////////////////////////////////////////////
  // Word clock source: pixel clock edges or internal oscillator
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) gap_r <= `SBCP_PCLK_LOSS_CYC;
    else if (clk_en) begin
      if (pclk_rise) gap_r <= 8'h00;
      else if (gap_r != `SBCP_PCLK_LOSS_CYC) gap_r <= gap_r + 8'h01;
    end
  end
  assign pclk_present = (gap_r != `SBCP_PCLK_LOSS_CYC);

  always_comb begin
    if (low_frequency_range) rate_nxt = SBCP_OSC_12P5;
    else if (osc25_r) rate_nxt = SBCP_OSC_25;
    else rate_nxt = SBCP_OSC_33;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      use_internal_oscillator <= 1'b0;
      osc_rate <= SBCP_OSC_33;
      pixel_range_low <= 1'b0;
    end else if (clk_en) begin
      if (in_st) use_internal_oscillator <= selftest_clock_select | ~pclk_present;
      else use_internal_oscillator <= pattern_gen_enable & ~pclk_present;
      osc_rate <= rate_nxt;
      pixel_range_low <= low_frequency_range;
    end
  end

  // Oscillator model: one word tick every osc_div mclk cycles
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) div_r <= 4'h0;
    else if (clk_en) div_r <= osc_tick ? 4'h0 : div_r + 4'h1;
  end
  assign osc_tick = (div_r >= osc_div(sbcp_osc_t'(osc_rate)) - 4'h1);
  assign word_stb = use_internal_oscillator ? osc_tick : pclk_rise;

  ////////////////////////////////////////////////////////////////////////
  // Payload source, scrambler and DC balance
  assign sending  = in_st | ~power_down;
  assign src_word = in_st ? 24'h000000 :
                    pattern_gen_enable ? {pat_r, ~pat_r, pat_r} : par_s2;
  assign scr_word = src_word ^ lfsr_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lfsr_r <= `SBCP_SCR_SEED;
      pat_r <= 8'h00;
      tx_word <= 24'h000000;
      tx_dc_invert <= 1'b0;
      tx_valid <= 1'b0;
    end else if (clk_en) begin
      tx_valid <= word_stb & sending;
      if (word_stb && sending) begin
        lfsr_r <= {lfsr_r[22:0], lfsr_r[23] ^ lfsr_r[22] ^ lfsr_r[21] ^ lfsr_r[16]};
        pat_r <= pat_r + 8'h01;
        tx_dc_invert <= (ones(scr_word) > `SBCP_DCB_HALF);
        tx_word <= (ones(scr_word) > `SBCP_DCB_HALF) ? ~scr_word : scr_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Back-channel CRC error counters
  assign crc_err = back_channel_crc_error & back_channel_locked;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      builtin_selftest_crc_count <= `SBCP_CNT_RST;
      func_crc_count <= `SBCP_CNT_RST;
      link_detect <= 1'b0;
    end else if (clk_en) begin
      link_detect <= back_channel_locked;
      if (entering) builtin_selftest_crc_count <= `SBCP_CNT_RST;
      else if (in_st && crc_err) builtin_selftest_crc_count <= sat_inc(builtin_selftest_crc_count);
      else if (bclr) builtin_selftest_crc_count <= `SBCP_CNT_RST;
      if (!in_st && crc_err) func_crc_count <= sat_inc(func_crc_count);
      else if (fclr) func_crc_count <= `SBCP_CNT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial control port registers
  assign bclr = wr_stb && (ptr == `SBCP_REG_CTRL) && wr_data[`SBCP_BCLR_BIT];
  assign fclr = wr_stb && (ptr == `SBCP_REG_CTRL) && wr_data[`SBCP_FCLR_BIT];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      osc25_r <= `SBCP_CTRL_RST;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      sda_oe <= slave_oe;
      if (wr_stb && ptr == `SBCP_REG_CTRL) osc25_r <= wr_data[`SBCP_OSC25_BIT];
    end
  end

  always_comb begin
    case (ptr)
      `SBCP_REG_STATUS:   rd_data = {7'h00, link_detect};
      `SBCP_REG_CTRL:     rd_data = {7'h00, osc25_r};
      `SBCP_REG_BUILTIN_SELFTEST_CNT: rd_data = builtin_selftest_crc_count;
      `SBCP_REG_FUNC_CNT: rd_data = func_crc_count;
      default:            rd_data = 8'h00;
    endcase
  end

  sbcp_i2c_slave u_slave (
    .mclk     (mclk),
    .reset    (reset),
    .clk_en   (clk_en),
    .dev_addr (device_address),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .rd_data  (rd_data),
    .sda_oe   (slave_oe),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .ptr      (ptr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  property p_no_compat;
    clk_en && backward_compat |=> !selftest_active && !wake_request;
  endproperty
  a_no_compat: assert property (p_no_compat) else $error("self-test in compat mode");
  property p_enter;
    clk_en && mode_r == SBCP_NORMAL && remote_selftest_enable && !backward_compat && !power_down
      |=> selftest_active;
  endproperty
  a_enter: assert property (p_enter) else $error("self-test not entered");
  property p_wake;
    clk_en && mode_r == SBCP_NORMAL && remote_selftest_enable && !backward_compat && power_down
      |=> wake_request && !selftest_active;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake before test");
  property p_zero;
    clk_en && in_st && word_stb |=> (tx_word ^ {24{tx_dc_invert}}) == $past(lfsr_r);
  endproperty
  a_zero: assert property (p_zero) else $error("test payload not zero");
  property p_scr;
    clk_en && word_stb && sending |=>
      tx_valid && ((tx_word ^ {24{tx_dc_invert}}) == $past(scr_word));
  endproperty
  a_scr: assert property (p_scr) else $error("payload bypassed scrambler");
  property p_osc33;
    clk_en && in_st && !pclk_present && !low_frequency_range && !osc25_r |=>
      use_internal_oscillator && osc_rate == SBCP_OSC_33;
  endproperty
  a_osc33: assert property (p_osc33) else $error("wrong test clock");
  property p_osc12;
    clk_en && low_frequency_range |=> osc_rate == SBCP_OSC_12P5 && pixel_range_low;
  endproperty
  a_osc12: assert property (p_osc12) else $error("low range rate wrong");
  property p_exit;
    clk_en && !remote_selftest_enable |=> !selftest_active && !wake_request;
  endproperty
  a_exit: assert property (p_exit) else $error("self-test not left");
  property p_unlocked;
    clk_en && !back_channel_locked && !bclr && !fclr && !entering |=>
      $stable(builtin_selftest_crc_count) && $stable(func_crc_count);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("counted without lock");
  property p_clear;
    clk_en && entering |=> builtin_selftest_crc_count == `SBCP_CNT_RST;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared on entry");
  property p_func;
    clk_en && !in_st && crc_err && func_crc_count != `SBCP_CNT_MAX |=>
      func_crc_count == $past(func_crc_count) + 8'h01;
  endproperty
  a_func: assert property (p_func) else $error("functional count missed");
  property p_hold;
    clk_en && !in_st && !entering && !bclr |=> $stable(builtin_selftest_crc_count);
  endproperty
  a_hold: assert property (p_hold) else $error("self-test count changed");

  c_entry: cover property (clk_en && entering);
  c_wake_run: cover property (wake_request ##[1:50] selftest_active);
  c_err_in_test: cover property (clk_en && in_st && crc_err);
  c_exit: cover property (selftest_active ##1 !selftest_active);
endmodule
`default_nettype wire

// file: core/README_unused.sv
`timescale 1ns/1ns

// file: test/sbcp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbcp_host_model (
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic m_low;
  // Pull-up: the wire is low only while someone pulls it
  assign sda = !(m_low || sda_oe);
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start();
    tk(2); m_low = 1'b0; tk(8); scl = 1'b1; tk(10); m_low = 1'b1; tk(10); scl = 1'b0;
  endtask
  task automatic stop();
    tk(2); m_low = 1'b1; tk(8); scl = 1'b1; tk(10); m_low = 1'b0; tk(10);
  endtask
  // Host ack bit: hack high pulls low (ack), low releases (nack)
  task automatic xfer(input logic [7:0] tx, input logic hack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      tk(2); m_low = !tx[i]; tk(8); scl = 1'b1; tk(10); rx[i] = sda; scl = 1'b0;
    end
    tk(2); m_low = hack; tk(8); scl = 1'b1; tk(10); ack = !sda; scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sbcp_pkg::*;
  logic mclk, reset, en, compat, pd, pgen, lfr, csel, pclk, locked, crc;
  logic [23:0] pdata, tx_word;
  logic [7:0] strap, bcnt, fcnt, rx;
  logic [6:0] dev_addr;
  logic [1:0] osc_rate;
  logic scl, sda, sda_oe, tx_inv, tx_valid, st_act, wake, prl, ldet, ack;
  logic sda_o, uio, st_prev, pass_flag;
  logic pclk_run = 1'b1;
  logic [23:0] rx_lfsr;
  wire [23:0] rx_word = (tx_inv ? ~tx_word : tx_word) ^ rx_lfsr;
  int seed = 32'hcee0;
  int fail_count = 0;
  int tests_run = 0;
  int txn = 0;
  logic exp_q[$];
  sbcp_top u_sbcp_top (.mclk(mclk), .reset(reset), .clk_en(1'b1), .remote_selftest_enable(en),
    .backward_compat(compat), .power_down(pd), .pattern_gen_enable(pgen), .low_frequency_range(lfr),
    .selftest_clock_select(csel), .pixel_clock(pclk), .parallel_data(pdata), .back_channel_locked(locked),
    .back_channel_crc_error(crc), .address_strap_pin_code(strap), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .tx_word(tx_word), .tx_dc_invert(tx_inv), .tx_valid(tx_valid),
    .selftest_active(st_act), .wake_request(wake), .use_internal_oscillator(uio), .osc_rate(osc_rate),
    .pixel_range_low(prl), .builtin_selftest_crc_count(bcnt), .func_crc_count(fcnt), .link_detect(ldet),
    .device_address(dev_addr));
  sbcp_host_model u_sbcp_host_model (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    pclk = 1'b0;
    forever #400 pclk = ~pclk & pclk_run;
  end
  always @(negedge mclk) pdata <= 24'($random(seed));
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Mode changes are noted by the driver and compared when they show
  always @(st_act) begin
    if (!reset) begin
      if (exp_q.size() == 0) check("st_act unexpected", 8'(st_act), 8'hFF);
      else check("st_act", 8'(st_act), 8'(exp_q.pop_front()));
    end
  end
  // Far-end receiver: descramble, compare test payloads with zero, keep the pass flag
  always @(negedge mclk) begin
    st_prev <= st_act;
    if (reset) begin
      rx_lfsr <= 24'hFFFFFF;
      pass_flag <= 1'b1;
    end else begin
      if (st_act && !st_prev) pass_flag <= 1'b1;
      else if (tx_valid && st_prev && rx_word != 24'h000000) pass_flag <= 1'b0;
      if (tx_valid) begin
        txn <= txn + 1;
        rx_lfsr <= {rx_lfsr[22:0], rx_lfsr[23] ^ rx_lfsr[22] ^ rx_lfsr[21] ^ rx_lfsr[16]};
        check("dc balance", 8'($countones(tx_word) <= 12), 8'h01);
        if (st_prev) check("zero payload", 8'(|rx_word), 8'h00);
      end
    end
  end
  task automatic tk(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      tk(1); crc = 1'b1; tk(1); crc = 1'b0;
    end
  endtask
  task automatic selftest(input logic v);
    exp_q.push_back(v);
    tk(1); en = v; tk(3);
    if (!v) check("pass flag", 8'(pass_flag), 8'h01);
  endtask
  task automatic wr_byte(input logic [7:0] b, input string nm);
    u_sbcp_host_model.xfer(b, 1'b0, rx, ack);
    check(nm, 8'(ack), 8'h01);
  endtask
  initial begin
    {en, compat, pd, pgen, lfr, csel, locked, crc} = 8'h00;
    strap = 8'($random(seed)) & 8'h0F;
    reset = 1'b1;
    tk(10); reset = 1'b0; tk(4);
    check("dev_addr", 8'(dev_addr), 8'h0C);
    compat = 1'b1; en = 1'b1; tk(5);
    check("compat blocks", 8'(st_act), 8'h00);
    en = 1'b0; compat = 1'b0; tk(2); $display("test compat done");
    locked = 1'b1; tk(3); errs(3);
    selftest(1'b1);
    txn = 0;
    for (int i = 0; i < 100 && txn == 0; i++) tk(1);
    if (txn == 0) begin
      fail_count++;
      summarize();
    end
    errs(5); locked = 1'b0; errs(2); locked = 1'b1; tk(3);
    check("builtin_selftest cnt", bcnt, 8'h05);
    check("func in test", fcnt, 8'h03);
    selftest(1'b0); errs(2); tk(2);
    check("func cnt", fcnt, 8'h05);
    check("builtin_selftest hold", bcnt, 8'h05);
    selftest(1'b1);
    check("builtin_selftest entry clr", bcnt, 8'h00);
    errs(4); selftest(1'b0); $display("test counters done");
    pd = 1'b1; en = 1'b1; tk(3);
    check("wake", 8'(wake), 8'h01);
    check("no test yet", 8'(st_act), 8'h00);
    exp_q.push_back(1'b1); pd = 1'b0; tk(3);
    check("wake off", 8'(wake), 8'h00);
    errs(3);
    selftest(1'b0);
    check("builtin_selftest before clr", bcnt, 8'h03);
    $display("test wake done");
    u_sbcp_host_model.start();
    wr_byte(8'h18, "addr ack");
    wr_byte(8'h14, "ptr ack");
    wr_byte(8'h02, "data ack");
    u_sbcp_host_model.stop(); tk(3);
    check("builtin_selftest clr", bcnt, 8'h00);
    u_sbcp_host_model.start();
    wr_byte(8'h18, "addr ack");
    wr_byte(8'h0C, "ptr ack");
    u_sbcp_host_model.start();
    wr_byte(8'h19, "rd addr ack");
    u_sbcp_host_model.xfer(8'hFF, 1'b0, rx, ack);
    u_sbcp_host_model.stop();
    check("lock status", rx, 8'h01);
    u_sbcp_host_model.start();
    u_sbcp_host_model.xfer(8'h1A, 1'b0, rx, ack);
    u_sbcp_host_model.stop();
    check("addr nack", 8'(ack), 8'h00);
    $display("test bus done");
    check("link det", 8'(ldet), 8'h01);
    check("sda out", 8'(sda_o), 8'h00);
    pclk_run = 1'b0; tk(30);
    check("no osc idle", 8'(uio), 8'h00);
    pgen = 1'b1; tk(3);
    check("osc pattern", 8'(uio), 8'h01);
    txn = 0; tk(10);
    check("osc words", 8'(txn > 0), 8'h01);
    selftest(1'b1);
    check("osc in test", 8'(uio), 8'h01);
    check("osc33 in test", 8'(osc_rate), 8'h00);
    selftest(1'b0);
    pgen = 1'b0; pclk_run = 1'b1; tk(30);
    $display("test oscillator done");
    check("osc normal", 8'(osc_rate), 8'h00);
    lfr = 1'b1; tk(3);
    check("range low", 8'(prl), 8'h01);
    check("osc low", 8'(osc_rate), 8'h02);
    $display("test range done");
    strap = 8'hB0; reset = 1'b1; tk(2); reset = 1'b0; tk(4);
    check("strap top", 8'(dev_addr), 8'h1B);
    $display("test strap done");
    summarize();
  end
endmodule
`default_nettype wire
